// *** pkg/isw_pkg.sv ***
/*
 * isw_pkg: constants, register map and state type shared by the interrupt
 * and sleep wake-up controller.
 * Assumes a 32-bit classic Wishbone bus with word-aligned registers.
 */
package isw_pkg;

  // ****************************************************************
  // register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [4:0] ADDR_IRQ_CTRL  = 5'h00; // interrupt_control_reg
  localparam logic [4:0] ADDR_OPTION    = 5'h04; // edge select lives here
  localparam logic [4:0] ADDR_PFLAG_A   = 5'h08; // peripheral_flag_reg_a
  localparam logic [4:0] ADDR_PFLAG_B   = 5'h0C; // peripheral_flag_reg_b
  localparam logic [4:0] ADDR_PEN_A     = 5'h10; // peripheral_enable_reg_a
  localparam logic [4:0] ADDR_PEN_B     = 5'h14; // peripheral_enable_reg_b
  localparam logic [4:0] ADDR_PWR_STAT  = 5'h18; // timeout / powerdown flags

  // ****************************************************************
  // interrupt_control_reg fields
  // ****************************************************************
  localparam int BIT_GIE       = 7; // global_irq_enable
  localparam int BIT_PEIE      = 6; // peripheral group enable
  localparam int BIT_TMR_EN    = 5; // timer_overflow_enable
  localparam int BIT_EXT_EN    = 4; // ext_irq_enable
  localparam int BIT_PORT_EN   = 3; // port_change_enable
  localparam int BIT_TMR_FLAG  = 2; // timer_overflow_flag
  localparam int BIT_EXT_FLAG  = 1; // ext_irq_flag
  localparam int BIT_PORT_FLAG = 0; // port_change_flag

  // option register and power status fields
  localparam int BIT_EDGE_SEL  = 6; // ext_edge_select
  localparam int BIT_TIMEOUT   = 4; // timeout_flag_n
  localparam int BIT_PWRDOWN   = 3; // powerdown_flag_n

  // ****************************************************************
  // reset values and fixed figures
  // ****************************************************************
  localparam logic [7:0]  IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0]  OPTION_RST   = 8'hFF;
  localparam logic [7:0]  PERIPH_RST   = 8'h00;
  localparam logic [7:0]  TIMER_MAX    = 8'hFF;
  localparam logic [7:0]  TIMER_ZERO   = 8'h00;
  localparam logic [12:0] VECTOR_ADDR  = 13'h0004;
  localparam int          DUMMY_CYCLES = 2;

  // core sequencing as seen by the controller
  typedef enum logic [2:0] {
    ISW_RUN,      // normal execution
    ISW_SLEEP,    // clocks stopped, waiting for an enabled flag
    ISW_WAKE,     // executing the instruction after sleep
    ISW_DUMMY     // dummy cycles before the vector instruction
  } isw_state_t;

endpackage : isw_pkg

// *** verilog/isw_ctrl.sv ***
/*
 * isw_ctrl: interrupt collection, gating and vectoring plus sleep / wake-up
 * sequencing, with a Wishbone register slave.
 * Assumes one clock per instruction cycle; pin inputs are asynchronous,
 * timer count, peripheral events and core strobes are on clk_i.
 */
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module isw_ctrl #(
  parameter int PC_W = 13                     // program counter width
) (
  input  wire logic            clk_i,          // instruction clock
  input  wire logic            rst_i,          // synchronous reset
  // wishbone slave
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [4:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // event sources
  input  wire logic            ext_irq_pin_i,      // asynchronous pin
  input  wire logic [3:0]      change_sense_port_i, // upper port pins 7..4
  input  wire logic [7:0]      timer_zero_count_i, // timer count value
  input  wire logic [7:0]      periph_event_a_i,   // one-cycle set pulses
  input  wire logic [7:0]      periph_event_b_i,
  // core strobes
  input  wire logic [PC_W-1:0] pc_i,               // address of current instr
  input  wire logic            sleep_exec_i,       // sleep instruction strobe
  input  wire logic            return_from_irq_instr_i,
  input  wire logic            watchdog_clear_instr_i,
  // core controls
  output logic                 vector_o,           // take interrupt now
  output logic [PC_W-1:0]      vector_addr_o,
  output logic                 push_o,             // push return address
  output logic [PC_W-1:0]      push_addr_o,
  output logic                 prefetch_o,         // fetch after sleep
  output logic [PC_W-1:0]      prefetch_addr_o,
  output logic                 asleep_o,
  output logic                 exec_next_o,        // run instr after sleep
  output logic                 dummy_o,            // dummy cycle
  output logic                 sleep_nop_o,        // sleep ran as no-op
  output logic                 wdt_clear_o,        // clear watchdog+postscaler
  output logic                 timeout_flag_n_o,
  output logic                 powerdown_flag_n_o
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0]          irq_ctrl;        // interrupt_control_reg
  logic [7:0]          option;          // holds ext_edge_select
  logic [7:0]          pflag_a;         // peripheral_flag_reg_a
  logic [7:0]          pflag_b;         // peripheral_flag_reg_b
  logic [7:0]          pen_a;           // peripheral_enable_reg_a
  logic [7:0]          pen_b;           // peripheral_enable_reg_b
  logic                timeout_flag_n;
  logic                powerdown_flag_n;
  isw_pkg::isw_state_t state;
  logic                dummy_cnt;       // second dummy cycle marker

  // synchronisers: first stage is read only by the second
  logic       ext_s1, ext_s2, ext_s3;
  logic [3:0] port_s1, port_s2, port_s3;
  logic [7:0] timer_prev;

  // ****************************************************************
  // event detection
  // ****************************************************************
  // pin and port cross into clk_i through two flops; third flop is history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
      port_s1 <= 4'h0;
      port_s2 <= 4'h0;
      port_s3 <= 4'h0;
    end else begin
      ext_s1  <= ext_irq_pin_i;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      port_s1 <= change_sense_port_i;
      port_s2 <= port_s1;
      port_s3 <= port_s2;
    end
  end

  // timer history for rollover detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_prev <= isw_pkg::TIMER_ZERO;
    end else begin
      timer_prev <= timer_zero_count_i;
    end
  end

  logic edge_sel;
  logic ext_event;
  logic port_event;
  logic tmr_event;
  logic asleep;

  assign asleep   = (state == isw_pkg::ISW_SLEEP);
  assign edge_sel = option[isw_pkg::BIT_EDGE_SEL];
  // rising edge with select set, falling with it clear
  assign ext_event  = edge_sel ? (ext_s2 & ~ext_s3) : (~ext_s2 & ext_s3);
  assign port_event = |(port_s2 ^ port_s3);
  // timer runs on an on-chip clock: no rollover counts while asleep
  assign tmr_event  = ~asleep && (timer_prev == isw_pkg::TIMER_MAX)
                      && (timer_zero_count_i == isw_pkg::TIMER_ZERO);

  // ****************************************************************
  // pending computation
  // ****************************************************************
  logic periph_pend;
  logic pend_en;   // some source has flag and enable (ignores global)
  logic take;

  // peripheral group gated by its own enable bit
  assign periph_pend = irq_ctrl[isw_pkg::BIT_PEIE]
                       & |((pflag_a & pen_a) | (pflag_b & pen_b));
  assign pend_en = periph_pend
    | (irq_ctrl[isw_pkg::BIT_EXT_EN]  & irq_ctrl[isw_pkg::BIT_EXT_FLAG])
    | (irq_ctrl[isw_pkg::BIT_TMR_EN]  & irq_ctrl[isw_pkg::BIT_TMR_FLAG])
    | (irq_ctrl[isw_pkg::BIT_PORT_EN] & irq_ctrl[isw_pkg::BIT_PORT_FLAG]);

  // vector only from normal run or right after the inline instruction
  assign take = pend_en && irq_ctrl[isw_pkg::BIT_GIE]
                && ((state == isw_pkg::ISW_RUN && !sleep_exec_i)
                    || state == isw_pkg::ISW_WAKE);

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes act once, at the edge where the master samples ack high;
  // low lane carries data
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  function automatic logic wr_hit(input logic [4:0] a);
    return wb_wr && (wb_adr_i == a);
  endfunction : wr_hit

  // one-cycle ack; unmapped reads return zero, unmapped writes vanish
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        unique case (wb_adr_i)
          isw_pkg::ADDR_IRQ_CTRL: wb_dat_o <= {24'h00_0000, irq_ctrl};
          isw_pkg::ADDR_OPTION:   wb_dat_o <= {24'h00_0000, option};
          isw_pkg::ADDR_PFLAG_A:  wb_dat_o <= {24'h00_0000, pflag_a};
          isw_pkg::ADDR_PFLAG_B:  wb_dat_o <= {24'h00_0000, pflag_b};
          isw_pkg::ADDR_PEN_A:    wb_dat_o <= {24'h00_0000, pen_a};
          isw_pkg::ADDR_PEN_B:    wb_dat_o <= {24'h00_0000, pen_b};
          isw_pkg::ADDR_PWR_STAT: wb_dat_o <= {27'h000_0000, timeout_flag_n,
                                               powerdown_flag_n, 3'h0};
          default:                wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // interrupt control register
  // ****************************************************************
  // hardware sets win over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ctrl <= isw_pkg::IRQ_CTRL_RST;
    end else begin
      if (wr_hit(isw_pkg::ADDR_IRQ_CTRL)) begin
        irq_ctrl <= wb_dat_i[7:0];
      end
      // the return instruction re-opens interrupts
      if (return_from_irq_instr_i) begin
        irq_ctrl[isw_pkg::BIT_GIE] <= 1'b1;
      end
      // taking closes them; wins over a write or a return
      if (take) begin
        irq_ctrl[isw_pkg::BIT_GIE] <= 1'b0;
      end
      // flags follow events whatever the enables say
      if (ext_event) begin
        irq_ctrl[isw_pkg::BIT_EXT_FLAG] <= 1'b1;
      end
      if (tmr_event) begin
        irq_ctrl[isw_pkg::BIT_TMR_FLAG] <= 1'b1;
      end
      if (port_event) begin
        irq_ctrl[isw_pkg::BIT_PORT_FLAG] <= 1'b1;
      end
    end
  end

  // option register: only the edge select is used here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option <= isw_pkg::OPTION_RST;
    end else if (wr_hit(isw_pkg::ADDR_OPTION)) begin
      option <= wb_dat_i[7:0];
    end
  end

  // ****************************************************************
  // peripheral flags and enables
  // ****************************************************************
  // peripheral events need on-chip clocks, so sleep masks them
  logic [7:0] pev_a;
  logic [7:0] pev_b;
  assign pev_a = asleep ? 8'h00 : periph_event_a_i;
  assign pev_b = asleep ? 8'h00 : periph_event_b_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pflag_a <= isw_pkg::PERIPH_RST;
      pflag_b <= isw_pkg::PERIPH_RST;
    end else begin
      // the event is or-ed in after the write so a set is never lost
      pflag_a <= (wr_hit(isw_pkg::ADDR_PFLAG_A) ? wb_dat_i[7:0] : pflag_a) | pev_a;
      pflag_b <= (wr_hit(isw_pkg::ADDR_PFLAG_B) ? wb_dat_i[7:0] : pflag_b) | pev_b;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pen_a <= isw_pkg::PERIPH_RST;
      pen_b <= isw_pkg::PERIPH_RST;
    end else begin
      if (wr_hit(isw_pkg::ADDR_PEN_A)) begin
        pen_a <= wb_dat_i[7:0];
      end
      if (wr_hit(isw_pkg::ADDR_PEN_B)) begin
        pen_b <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************************************
  // sleep / wake sequencer
  // ****************************************************************
  logic sleep_now;   // sleep completes in full this cycle
  logic sleep_nop;   // sleep degrades to a no-op
  assign sleep_now = sleep_exec_i && (state == isw_pkg::ISW_RUN) && !pend_en;
  assign sleep_nop = sleep_exec_i && (state == isw_pkg::ISW_RUN) && pend_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= isw_pkg::ISW_RUN;
      dummy_cnt <= 1'b0;
    end else begin
      unique case (state)
        isw_pkg::ISW_RUN: begin
          if (sleep_now) begin
            state <= isw_pkg::ISW_SLEEP;
          end
        end
        isw_pkg::ISW_SLEEP: begin
          // wake needs only flag and enable, global enable is ignored
          if (pend_en) begin
            state <= isw_pkg::ISW_WAKE;
          end
        end
        isw_pkg::ISW_WAKE: begin
          // with global enable set, vector after the inline instruction
          if (take) begin
            state     <= isw_pkg::ISW_DUMMY;
            dummy_cnt <= 1'b0;
          end else begin
            state <= isw_pkg::ISW_RUN;
          end
        end
        isw_pkg::ISW_DUMMY: begin
          dummy_cnt <= 1'b1;
          if (dummy_cnt) begin
            state <= isw_pkg::ISW_RUN;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // core control outputs
  // ****************************************************************
  // only the return address is handed to the stack; w and status are not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_o      <= 1'b0;
      vector_addr_o <= '0;
      push_o        <= 1'b0;
      push_addr_o   <= '0;
    end else begin
      vector_o <= take;
      push_o   <= take;
      if (take) begin
        vector_addr_o <= PC_W'(isw_pkg::VECTOR_ADDR);
        push_addr_o   <= pc_i;
      end
    end
  end

  // prefetch of the following address accompanies every sleep taken in the run state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefetch_o      <= 1'b0;
      prefetch_addr_o <= '0;
    end else begin
      prefetch_o <= sleep_exec_i && (state == isw_pkg::ISW_RUN);
      if (sleep_exec_i) begin
        prefetch_addr_o <= pc_i + PC_W'(1);
      end
    end
  end

  // watchdog and power flags: a full sleep clears the watchdog
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_clear_o      <= 1'b0;
      sleep_nop_o      <= 1'b0;
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else begin
      wdt_clear_o <= sleep_now || watchdog_clear_instr_i;
      sleep_nop_o <= sleep_nop;
      if (sleep_now) begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b0;
      end else if (watchdog_clear_instr_i) begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
    end
  end

  assign asleep_o           = asleep;
  assign exec_next_o        = (state == isw_pkg::ISW_WAKE);
  assign dummy_o            = (state == isw_pkg::ISW_DUMMY);
  assign timeout_flag_n_o   = timeout_flag_n;
  assign powerdown_flag_n_o = powerdown_flag_n;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ext_flag_set: assert property (ext_event |=> irq_ctrl[isw_pkg::BIT_EXT_FLAG])
    else $error("pin edge did not set its flag");
  a_tmr_flag_set: assert property (tmr_event |=> irq_ctrl[isw_pkg::BIT_TMR_FLAG])
    else $error("timer rollover did not set its flag");
  a_take_needs_gie: assert property ($rose(vector_o)
                                      |-> $past(irq_ctrl[isw_pkg::BIT_GIE]))
    else $error("vector taken with global enable clear");
  a_take_clears_gie: assert property (vector_o |-> !irq_ctrl[isw_pkg::BIT_GIE]
                                       && push_o && vector_addr_o == isw_pkg::VECTOR_ADDR)
    else $error("vector entry incomplete");
  a_return_sets_gie: assert property (return_from_irq_instr_i && !take |=>
                                       irq_ctrl[isw_pkg::BIT_GIE])
    else $error("return did not re-enable interrupts");
  a_ext_latency: assert property (ext_event && irq_ctrl[isw_pkg::BIT_EXT_EN]
                                   && irq_ctrl[isw_pkg::BIT_GIE] && state == isw_pkg::ISW_RUN
                                   && !sleep_exec_i && !wb_wr |-> ##[1:2] vector_o)
    else $error("external event latency exceeded");
  a_sleep_as_nop: assert property (sleep_nop |=> sleep_nop_o && !wdt_clear_o
                                    && powerdown_flag_n == $past(powerdown_flag_n)
                                    && state == isw_pkg::ISW_RUN)
    else $error("pending sleep did not act as no-op");
  a_sleep_full: assert property (sleep_now |=> wdt_clear_o && timeout_flag_n
                                  && !powerdown_flag_n && asleep)
    else $error("full sleep side effects missing");
  a_wake_inline: assert property (asleep && pend_en |=> exec_next_o ##1 !asleep)
    else $error("wake did not run the inline instruction");
  a_dummy_pair: assert property ($rose(dummy_o) |-> dummy_o[*2] ##1 !dummy_o)
    else $error("dummy cycles not exactly two");

  c_vector_run: cover property (state == isw_pkg::ISW_RUN ##1 vector_o);
  c_wake_vector: cover property (exec_next_o && take ##1 dummy_o);
  c_wake_inline: cover property (exec_next_o && !take);
  c_sleep_nop: cover property (sleep_nop);

endmodule : isw_ctrl

`default_nettype wire

// *** tb/isw_core_model.sv ***
/* isw_core_model: far-side model of the core's program counter and stack.
   assumes clk_i is the instruction clock and controller pulses last one cycle. */
`timescale 1ns/1ps
`default_nettype none
module isw_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        vector_i,
  input  wire logic [12:0] vector_addr_i,
  input  wire logic        push_i,
  input  wire logic [12:0] push_addr_i,
  input  wire logic        asleep_i,
  output logic      [12:0] pc_o,
  output logic      [12:0] top_o
);
  // pc steps once a cycle, jumps on a take and holds while clocks are stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) pc_o <= 13'h0100;
    else if (vector_i) pc_o <= vector_addr_i;
    else if (!asleep_i) pc_o <= pc_o + 13'h0001;
  end
  // one stack slot is enough here: only the return address is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) top_o <= 13'h0000;
    else if (push_i) top_o <= push_addr_i;
  end
endmodule : isw_core_model
`default_nettype wire

// *** tb/isw_ctrl_tb.sv ***
/* isw_ctrl_tb: directed bench for the interrupt and wake-up controller.
   assumes the controller answers each bus request with one ack pulse. */
`timescale 1ns/1ps
`default_nettype none
module isw_ctrl_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pin = 0, slp = 0, ret = 0, wdi = 0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0]  port = 4'h0;
  logic [7:0]  tmr = 8'h00, pev = 8'h00, q;
  logic [12:0] pc, top, vaddr, paddr, pad, p;
  logic        ack, vec, push, pf, asl, exn, dmy, nop, wdc, to_n, pd_n;
  int          num_errors = 0, num_checks = 0, cyc_cnt = 0, n;
  // ****************************************************************
  // clock, timeout, instances
  // ****************************************************************
  initial forever #2.5 clk_i = ~clk_i;
  // a hang ends the run through the same closing report
  always @(posedge clk_i) if (++cyc_cnt > 4000) begin num_errors++; tally_and_finish(); end
  isw_ctrl isw_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_irq_pin_i(pin), .change_sense_port_i(port),
    .timer_zero_count_i(tmr), .periph_event_a_i(pev), .periph_event_b_i(pev),
    .pc_i(pc), .sleep_exec_i(slp), .return_from_irq_instr_i(ret),
    .watchdog_clear_instr_i(wdi), .vector_o(vec), .vector_addr_o(vaddr), .push_o(push),
    .push_addr_o(pad), .prefetch_o(pf), .prefetch_addr_o(paddr), .asleep_o(asl),
    .exec_next_o(exn), .dummy_o(dmy), .sleep_nop_o(nop), .wdt_clear_o(wdc),
    .timeout_flag_n_o(to_n), .powerdown_flag_n_o(pd_n));
  isw_core_model isw_core_model_i (.clk_i(clk_i), .rst_i(rst_i), .vector_i(vec),
    .vector_addr_i(vaddr), .push_i(push), .push_addr_i(pad),
    .asleep_i(asl), .pc_o(pc), .top_o(top));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [12:0] got, input logic [12:0] exp);
    num_checks++;
    if (got !== exp) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end
  endtask : chk
  // classic cycle: hold the request until ack is sampled high, then release
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    n = 0;
    @(posedge clk_i); cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1);
    q = rdat[7:0]; cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
    wb(0, a, 8'h00); chk(nm, {5'h0, q}, {5'h0, e});
  endtask : rd
  // pulse a strobe for one cycle, then look at the cycle after it is taken
  task automatic sleep_pulse();
    @(posedge clk_i); slp <= 1; @(posedge clk_i); slp <= 0; p = pc; @(posedge clk_i);
  endtask : sleep_pulse
  task automatic wait_sig(input int sel);
    n = 0;
    do begin @(posedge clk_i); n++; end while ((sel ? exn : vec) !== 1'b1 && n < 12);
  endtask : wait_sig
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_pin_take();
    wb(1, isw_pkg::ADDR_OPTION, 8'h40); wb(1, isw_pkg::ADDR_IRQ_CTRL, 8'h90);
    @(posedge clk_i); pin <= 1; wait_sig(0); p = pc;
    chk("latency", 13'(n >= 4 && n <= 5), 13'h1);
    chk("push", {12'h0, push}, 13'h1); chk("vector", vaddr, 13'h0004);
    @(posedge clk_i); chk("pc", pc, 13'h0004);
    chk("ret addr", top, p - 13'h1);
    rd("ctrl", isw_pkg::ADDR_IRQ_CTRL, 8'h12);
    // clear the flag first, or the return would re-enter at once
    wb(1, isw_pkg::ADDR_IRQ_CTRL, 8'h10);
    @(posedge clk_i); ret <= 1; @(posedge clk_i); ret <= 0;
    rd("ret", isw_pkg::ADDR_IRQ_CTRL, 8'h90);
    $display("pin take done");
  endtask : t_pin_take
  task automatic t_flags();
    wb(1, isw_pkg::ADDR_IRQ_CTRL, 8'h00); wb(1, isw_pkg::ADDR_PEN_A, 8'h01);
    // falling-edge select: the pin drop below must set the pin flag
    wb(1, isw_pkg::ADDR_OPTION, 8'h00);
    @(posedge clk_i); tmr <= 8'hFF; pin <= 0;
    @(posedge clk_i); tmr <= 8'h00; port <= 4'h8;
    @(posedge clk_i); pev <= 8'h01; @(posedge clk_i); pev <= 8'h00;
    rd("ctrl", isw_pkg::ADDR_IRQ_CTRL, 8'h07);
    rd("pflag", isw_pkg::ADDR_PFLAG_A, 8'h01);
    rd("pflag b", isw_pkg::ADDR_PFLAG_B, 8'h01);
    wb(1, isw_pkg::ADDR_OPTION, 8'h40);
    wb(1, isw_pkg::ADDR_IRQ_CTRL, 8'h80); wait_sig(0);
    chk("no group", {12'h0, vec}, 13'h0);
    wb(1, isw_pkg::ADDR_IRQ_CTRL, 8'hC0); wait_sig(0);
    chk("group", {12'h0, vec}, 13'h1);
    wb(1, isw_pkg::ADDR_PFLAG_A, 8'h00); wb(1, isw_pkg::ADDR_PEN_A, 8'h00);
    $display("flag gating done");
  endtask : t_flags
  // a wake with the global enable picked by global_irq_enable
  task automatic t_sleep(input logic global_irq_enable);
    @(posedge clk_i); pin <= 0;
    wb(1, isw_pkg::ADDR_IRQ_CTRL, {global_irq_enable, 7'h10});
    sleep_pulse();
    chk("asleep", {10'h0, asl, wdc, pf}, 13'h7); chk("pfa", paddr, p + 13'h1);
    chk("flags_n", {11'h0, to_n, pd_n}, 13'h2);
    @(posedge clk_i); pin <= 1; wait_sig(1);
    chk("wake", {12'h0, exn}, 13'h1);
    @(posedge clk_i); chk("vec after", {12'h0, vec}, {12'h0, global_irq_enable});
    chk("dummy", {12'h0, dmy}, {12'h0, global_irq_enable});
    @(posedge clk_i); chk("dummy", {12'h0, dmy}, {12'h0, global_irq_enable});
    @(posedge clk_i); chk("dummy end", {11'h0, dmy, asl}, 13'h0);
    $display("sleep wake done");
  endtask : t_sleep
  task automatic t_sleep_nop();
    // the clear instruction raises both flags, so a wrong full sleep would show
    @(posedge clk_i); wdi <= 1; @(posedge clk_i); wdi <= 0;
    @(posedge clk_i); chk("wdt clr", {12'h0, wdc}, 13'h1);
    wb(1, isw_pkg::ADDR_IRQ_CTRL, 8'h12);
    rd("stat", isw_pkg::ADDR_PWR_STAT, 8'h18);
    sleep_pulse();
    chk("nop", {10'h0, nop, asl, wdc}, 13'h4);
    rd("stat", isw_pkg::ADDR_PWR_STAT, 8'h18);
    $display("sleep nop done");
  endtask : t_sleep_nop
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    rd("ctrl rst", isw_pkg::ADDR_IRQ_CTRL, 8'h00);
    rd("stat rst", isw_pkg::ADDR_PWR_STAT, 8'h18);
    t_pin_take(); t_flags(); t_sleep(0); t_sleep(1); t_sleep_nop();
    tally_and_finish();
  end
endmodule : isw_ctrl_tb
`default_nettype wire
